// ===== common/ips_map.vh
`ifndef IPS_MAP_VH
`define IPS_MAP_VH

// register byte offsets
`define IPS_OFF_GRP3 6'h00
`define IPS_OFF_GRP4 6'h04
`define IPS_OFF_GRP5 6'h08
`define IPS_OFF_GRP7 6'h0C
`define IPS_OFF_GRP14 6'h10
`define IPS_OFF_GRP15 6'h14
`define IPS_OFF_GRP16 6'h18
`define IPS_OFF_GRP18 6'h1C
`define IPS_OFF_STATUS 6'h20
`define IPS_OFF_PENDING 6'h24

// field positions (lsb of each field; priority fields are three bits, level four, vector seven)
`define IPS_POS_CONVERTER_DONE 4
`define IPS_POS_SERIAL_TX 0
`define IPS_POS_PIN_CHANGE 12
`define IPS_POS_TWOWIRE_MASTER 4
`define IPS_POS_TWOWIRE_SLAVE 0
`define IPS_POS_CAPTURE_CH8 12
`define IPS_POS_CAPTURE_CH7 8
`define IPS_POS_EXT_PIN1 0
`define IPS_POS_EXT_PIN2 4
`define IPS_POS_QUAD_ENCODER 8
`define IPS_POS_PWM1_ERR 4
`define IPS_POS_PWM1_FAULT 12
`define IPS_POS_SERIAL_ERR 4
`define IPS_POS_PWM2_FAULT 8
`define IPS_POS_PWM2_ERR 4
`define IPS_POS_LEVEL 8
`define IPS_POS_VECTOR 0

// reset values
`define IPS_RST_PRIO 3'h4
`define IPS_RST_PRIO_ZERO 3'h0
`define IPS_RST_LEVEL 4'h0
`define IPS_RST_VECTOR 7'h00

// pending vector codes (vector number minus eight), one per source
`define IPS_VEC_CONVERTER_DONE 7'h0D
`define IPS_VEC_SERIAL_TX 7'h0C
`define IPS_VEC_PIN_CHANGE 7'h13
`define IPS_VEC_TWOWIRE_MASTER 7'h12
`define IPS_VEC_TWOWIRE_SLAVE 7'h11
`define IPS_VEC_CAPTURE_CH8 7'h16
`define IPS_VEC_CAPTURE_CH7 7'h15
`define IPS_VEC_EXT_PIN1 7'h14
`define IPS_VEC_EXT_PIN2 7'h1D
`define IPS_VEC_QUAD_ENCODER 7'h3A
`define IPS_VEC_PWM1_ERR 7'h39
`define IPS_VEC_PWM1_FAULT 7'h3C
`define IPS_VEC_SERIAL_ERR 7'h41
`define IPS_VEC_PWM2_FAULT 7'h4A
`define IPS_VEC_PWM2_ERR 7'h49

// bus responses
`define IPS_RESP_OKAY 2'h0
`define IPS_RESP_SLVERR 2'h2

`endif

// ===== verilog/ips_prio_field.v
`timescale 1ns/1ps
`include "ips_map.vh"

////////////////////////////////////////////////////////////////////////////
// one three-bit priority field with its own reset value
module ips_prio_field #(
    parameter [2:0] RST_VAL = `IPS_RST_PRIO
) (
    input wire aclk,
    input wire aresetn,
    input wire wr_en,
    input wire [2:0] wr_val,
    output reg [2:0] prio_q
);

    // field register, loaded by bus write, reset to its documented value
    always @(posedge aclk) begin
        if (!aresetn) begin
            prio_q <= RST_VAL;
        end else if (wr_en) begin
            prio_q <= wr_val;
        end
    end

endmodule // ips_prio_field

// ===== verilog/ips_top.v
`timescale 1ns/1ps
`include "ips_map.vh"

////////////////////////////////////////////////////////////////////////////
// interrupt priority fields, arbiter and status behind an axi4-lite slave
module ips_top (
    input wire aclk,
    input wire aresetn,
    // write address channel
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address channel
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // per-source request flags and enables
    input wire [14:0] irq_flag,
    input wire [14:0] irq_enable,
    // arbitration result towards the cpu core
    output reg [3:0] new_cpu_level_q,
    output reg [6:0] pending_vector_code_q,
    output reg irq_request_q
);

    ////////////////////////////////////////////////////////////////////////
    // source tables

    // number of request sources; a tie goes to the lower vector code, not the
    // lower index, so new sources can go at the end of the tables
    localparam integer NSRC = 15;

    // register index (offset / 4) holding each source's field
    function integer src_reg;
        input integer i;
        begin
            case (i)
                0, 1: src_reg = `IPS_OFF_GRP3 / 4;
                2, 3, 4: src_reg = `IPS_OFF_GRP4 / 4;
                5, 6, 7: src_reg = `IPS_OFF_GRP5 / 4;
                8: src_reg = `IPS_OFF_GRP7 / 4;
                9, 10: src_reg = `IPS_OFF_GRP14 / 4;
                11: src_reg = `IPS_OFF_GRP15 / 4;
                12: src_reg = `IPS_OFF_GRP16 / 4;
                default: src_reg = `IPS_OFF_GRP18 / 4;
            endcase
        end
    endfunction

    // bit position of each source's field inside its register
    function integer src_pos;
        input integer i;
        begin
            case (i)
                0: src_pos = `IPS_POS_CONVERTER_DONE;
                1: src_pos = `IPS_POS_SERIAL_TX;
                2: src_pos = `IPS_POS_PIN_CHANGE;
                3: src_pos = `IPS_POS_TWOWIRE_MASTER;
                4: src_pos = `IPS_POS_TWOWIRE_SLAVE;
                5: src_pos = `IPS_POS_CAPTURE_CH8;
                6: src_pos = `IPS_POS_CAPTURE_CH7;
                7: src_pos = `IPS_POS_EXT_PIN1;
                8: src_pos = `IPS_POS_EXT_PIN2;
                9: src_pos = `IPS_POS_QUAD_ENCODER;
                10: src_pos = `IPS_POS_PWM1_ERR;
                11: src_pos = `IPS_POS_PWM1_FAULT;
                12: src_pos = `IPS_POS_SERIAL_ERR;
                13: src_pos = `IPS_POS_PWM2_FAULT;
                default: src_pos = `IPS_POS_PWM2_ERR;
            endcase
        end
    endfunction

    // vector code reported when a source wins
    function [6:0] src_vec;
        input integer i;
        begin
            case (i)
                0: src_vec = `IPS_VEC_CONVERTER_DONE;
                1: src_vec = `IPS_VEC_SERIAL_TX;
                2: src_vec = `IPS_VEC_PIN_CHANGE;
                3: src_vec = `IPS_VEC_TWOWIRE_MASTER;
                4: src_vec = `IPS_VEC_TWOWIRE_SLAVE;
                5: src_vec = `IPS_VEC_CAPTURE_CH8;
                6: src_vec = `IPS_VEC_CAPTURE_CH7;
                7: src_vec = `IPS_VEC_EXT_PIN1;
                8: src_vec = `IPS_VEC_EXT_PIN2;
                9: src_vec = `IPS_VEC_QUAD_ENCODER;
                10: src_vec = `IPS_VEC_PWM1_ERR;
                11: src_vec = `IPS_VEC_PWM1_FAULT;
                12: src_vec = `IPS_VEC_SERIAL_ERR;
                13: src_vec = `IPS_VEC_PWM2_FAULT;
                default: src_vec = `IPS_VEC_PWM2_ERR;
            endcase
        end
    endfunction

    // reset value: level four everywhere except the pwm2 fault field
    function [2:0] src_rst;
        input integer i;
        begin
            if (i == 13) begin
                src_rst = `IPS_RST_PRIO_ZERO;
            end else begin
                src_rst = `IPS_RST_PRIO;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write path state

    reg [5:0] aw_addr_q; // held write address
    reg aw_full_q; // write address captured
    reg [31:0] w_data_q; // held write data
    reg [3:0] w_strb_q; // held byte strobes
    reg w_full_q; // write data captured
    wire wr_go; // both halves present, response slot free
    wire [3:0] wr_idx; // word index of write address
    wire wr_prio; // write targets a priority register
    wire wr_mapped; // write targets any register

    // a write is applied only once both halves are held and the previous
    // response is gone, so a stalled bready can never drop a write
    assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_idx = aw_addr_q[5:2];
    // status and pending words sit above the priority groups and are
    // never written; anything past the pending word is refused
    assign wr_prio = (aw_addr_q < `IPS_OFF_STATUS);
    assign wr_mapped = (aw_addr_q <= `IPS_OFF_PENDING);

    ////////////////////////////////////////////////////////////////////////
    // priority fields

    // one instance per source; the write enable picks register and lane
    wire [3*NSRC-1:0] prio_flat; // all fields, three bits per source

    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : gen_field
            localparam integer RIDX = src_reg(g);
            localparam integer POS = src_pos(g);
            // byte lane holding this field; a field never straddles lanes
            localparam integer LANE = POS / 8;
            wire we;
            // only the addressed register and the lane holding the field
            assign we = wr_go & wr_prio & (wr_idx == RIDX) &
                        w_strb_q[LANE];
            ips_prio_field #(
                .RST_VAL(src_rst(g))
            ) u_field (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(we),
                .wr_val(w_data_q[POS+2:POS]),
                .prio_q(prio_flat[3*g+2:3*g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // arbiter

    reg [2:0] best_lvl; // highest level seen so far
    reg [6:0] best_vec; // its vector code
    reg best_found; // any eligible source
    reg [14:0] eligible; // flagged, enabled and not disabled
    reg [2:0] lvl_i; // level of the source under test
    integer i;

    // pick the highest level, lower vector on a tie
    // strict greater-than keeps the earlier winner on an equal level, and
    // the code compare then decides; the scan is purely combinational, so
    // a field written on one edge already steers the status on the next
    always @* begin
        best_lvl = 3'h0;
        best_vec = 7'h00;
        best_found = 1'b0;
        eligible = 15'h0000;
        lvl_i = 3'h0;
        for (i = 0; i < NSRC; i = i + 1) begin
            lvl_i = prio_flat[3*i +: 3];
            // a zero field never takes part
            eligible[i] = irq_flag[i] & irq_enable[i] &
                          (lvl_i != 3'h0);
            if (eligible[i]) begin
                if (!best_found || lvl_i > best_lvl ||
                    (lvl_i == best_lvl && src_vec(i) < best_vec)) begin
                    best_lvl = lvl_i;
                    best_vec = src_vec(i);
                    best_found = 1'b1;
                end
            end
        end
    end

    // status registers follow the arbiter one cycle later
    // nothing eligible parks the status at level zero and vector code
    // zero, which software reads as cpu at level zero, nothing pending
    always @(posedge aclk) begin
        if (!aresetn) begin
            new_cpu_level_q <= `IPS_RST_LEVEL;
            pending_vector_code_q <= `IPS_RST_VECTOR;
            irq_request_q <= 1'b0;
        end else if (best_found) begin
            new_cpu_level_q <= {1'b0, best_lvl};
            pending_vector_code_q <= best_vec;
            irq_request_q <= 1'b1;
        end else begin
            new_cpu_level_q <= `IPS_RST_LEVEL;
            pending_vector_code_q <= `IPS_RST_VECTOR;
            irq_request_q <= 1'b0;
        end
    end

    // eligible set, held for software inspection
    // registered on the status edge, so a read sees the set behind it
    reg [14:0] pending_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= 15'h0000;
        end else begin
            pending_q <= eligible;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channels

    // capture address and data independently, in either order
    // readies stay low from their own handshake until the response is
    // taken, which keeps at most one write inside the block
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 6'h00;
            aw_full_q <= 1'b0;
            s_axi_awready <= 1'b1;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            w_full_q <= 1'b0;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPS_RESP_OKAY;
        end else begin
            // address handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            // data handshake
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // both present: field update happens on this same edge
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                // read-only words accept and ignore the write
                s_axi_bresp <= wr_mapped ? `IPS_RESP_OKAY :
                                           `IPS_RESP_SLVERR;
            end
            // response taken, reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    reg [31:0] rd_word; // word for the requested address
    reg rd_ok; // address mapped
    integer k;

    // fields placed at their positions, every other bit zero
    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (s_axi_araddr < `IPS_OFF_STATUS) begin
            for (k = 0; k < NSRC; k = k + 1) begin
                if (src_reg(k) == s_axi_araddr[5:2]) begin
                    rd_word[src_pos(k) +: 3] =
                        prio_flat[3*k +: 3];
                end
            end
        end else if (s_axi_araddr == `IPS_OFF_STATUS) begin
            rd_word[`IPS_POS_LEVEL +: 4] = new_cpu_level_q;
            rd_word[`IPS_POS_VECTOR +: 7] =
                pending_vector_code_q;
        end else if (s_axi_araddr == `IPS_OFF_PENDING) begin
            rd_word[14:0] = pending_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channels

    // one read in flight; data sampled on the address edge
    // the word is frozen in s_axi_rdata, so a field write landing while
    // the answer waits for rready does not change what software sees
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IPS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `IPS_RESP_OKAY :
                                       `IPS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // ips_top

// ===== bench/ips_src_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// peripheral side: registers the request flags and enables it is asked for
module ips_src_model (
    input logic aclk,
    input logic aresetn,
    input logic [14:0] set_flag,
    input logic [14:0] set_enable,
    output logic [14:0] irq_flag,
    output logic [14:0] irq_enable
);
    // sources come out of reset quiet, so priorities are set before enables
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag <= 15'h0000;
            irq_enable <= 15'h0000;
        end else begin
            irq_flag <= set_flag;
            irq_enable <= set_enable;
        end
    end
endmodule // ips_src_model

// ===== bench/ips_top_chk.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// bus and arbitration checks on the top ports
module ips_top_chk (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [5:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [14:0] irq_flag,
    input logic [14:0] irq_enable,
    input logic [3:0] new_cpu_level_q,
    input logic [6:0] pending_vector_code_q,
    input logic irq_request_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // no flagged and enabled source leaves the status idle
    a_idle_level: assert property (
        (irq_flag & irq_enable) == 15'h0000 |=>
        new_cpu_level_q == 4'h0 && !irq_request_q)
        else $error("status busy with no request");
    // user levels never pass seven
    a_level_range: assert property (
        new_cpu_level_q[3] == 1'b0)
        else $error("level above seven");
    // a request is raised exactly when a nonzero level wins
    a_req_level: assert property (
        irq_request_q == (new_cpu_level_q != 4'h0))
        else $error("request and level disagree");
    // status leaves reset cleared
    a_reset_status: assert property (
        $rose(aresetn) |-> new_cpu_level_q == 4'h0 &&
        pending_vector_code_q == 7'h00)
        else $error("status not cleared by reset");
    // read answer follows the address handshake
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // read data holds until taken
    a_rd_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // write response follows a joint handshake
    a_wr_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> ##[0:1] s_axi_bvalid)
        else $error("write response late");
    // unmapped reads return zero with an error
    a_unmapped_rd: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h24 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    c_request: cover property ($rose(irq_request_q));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ips_top_chk

bind ips_top ips_top_chk u_chk (.*);

// ===== bench/tb_interrupt_priority_and_status.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// register and arbitration bench for the priority block
module tb_interrupt_priority_and_status;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request_q;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, new_cpu_level_q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [14:0] irq_flag, irq_enable, set_flag, set_enable;
    logic [6:0] pending_vector_code_q;
    int n_errors = 0;
    int samples_checked = 0;
    // reset images and writable masks of the eight priority groups
    logic [15:0] rv [0:7] = '{16'h0044, 16'h4044, 16'h4404, 16'h0040,
                              16'h0440, 16'h4000, 16'h0040, 16'h0040};
    logic [15:0] mk [0:7] = '{16'h0077, 16'h7077, 16'h7707, 16'h0070,
                              16'h0770, 16'h7000, 16'h0070, 16'h0770};

    ips_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_flag,
        .irq_enable, .new_cpu_level_q, .pending_vector_code_q,
        .irq_request_q);
    ips_src_model src_u (.aclk, .aresetn, .set_flag, .set_enable,
        .irq_flag, .irq_enable);

    // 25 mhz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait ran out
    task automatic tmo();
        n_errors++;
        test_done();
    endtask

    // one axi write, address and data offered together
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
            n++;
            if (n > 40) tmo();
        end
    endtask

    // one axi read
    task automatic rd(input logic [5:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
            n++;
            if (n > 40) tmo();
        end
    endtask

    // status ports just after the edge, then the status register
    task automatic st(input logic [3:0] l, input logic [6:0] v);
        logic [31:0] d;
        logic [1:0] r;
        #1;
        chk({19'h0, irq_request_q, new_cpu_level_q, 1'b0,
             pending_vector_code_q}, {19'h0, l != 4'h0, l, 1'b0, v});
        rd(6'h20, d, r);
        chk(d, {20'h0, l, 1'b0, v});
    endtask

    // reset values of all groups and the status
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            rd(6'(i * 4), d, r);
            chk(d, {16'h0, rv[i]});
        end
        rd(6'h20, d, r);
        chk(d, 32'h0);
        rd(6'h24, d, r);
        chk(d, 32'h0);
    endtask

    // field layout, read-only status, unmapped place, strobes
    task automatic t_fields();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            wr(6'(i * 4), 32'hFFFF_FFFF, 4'hF, r);
            rd(6'(i * 4), d, r);
            chk(d, {16'h0, mk[i]});
        end
        wr(6'h20, 32'hFFFF_FFFF, 4'hF, r);
        chk({30'h0, r}, 32'h0);
        rd(6'h20, d, r);
        chk(d, 32'h0);
        wr(6'h28, 32'hFFFF_FFFF, 4'hF, r);
        chk({30'h0, r}, 32'h2);
        rd(6'h28, d, r);
        chk({r, d[29:0]}, {2'h2, 30'h0});
        wr(6'h00, 32'h0, 4'h2, r);
        rd(6'h00, d, r);
        chk(d, 32'h77);
        wr(6'h04, 32'h0, 4'h1, r);
        rd(6'h04, d, r);
        chk(d, 32'h7000);
    endtask

    // every level, ties, disable and enable gating
    task automatic t_arb();
        logic [1:0] r;
        logic [31:0] d;
        @(posedge aclk);
        set_flag <= 15'h0003;
        set_enable <= 15'h0003;
        for (int p = 0; p < 8; p++) begin
            wr(6'h00, 32'(p << 4), 4'hF, r);
            st(4'(p), (p != 0) ? 7'h0D : 7'h00);
        end
        wr(6'h00, 32'h33, 4'hF, r);
        st(4'h3, 7'h0C);
        wr(6'h00, 32'h17, 4'hF, r);
        st(4'h7, 7'h0C);
        wr(6'h00, 32'h71, 4'hF, r);
        st(4'h7, 7'h0D);
        @(posedge aclk);
        set_enable <= 15'h0000;
        repeat (3) @(posedge aclk);
        st(4'h0, 7'h00);
        @(posedge aclk);
        set_flag <= 15'h7FFF;
        set_enable <= 15'h7FFF;
        repeat (3) @(posedge aclk);
        st(4'h7, 7'h0D);
        wr(6'h20, 32'hFFFF_FFFF, 4'hF, r);
        st(4'h7, 7'h0D);
        wr(6'h00, 32'h0, 4'hF, r);
        st(4'h7, 7'h13);
        rd(6'h24, d, r);
        chk(d, 32'h7FE4);
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {set_flag, set_enable} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_arb();
        test_done();
    end
endmodule // tb_interrupt_priority_and_status
